// ---- rtl/tcp_defs.svh ----
/*
  timing and encoding constants for the trace output port.
  assumes inclusion by bare name; definitions only.
*/
`ifndef TCP_DEFS_SVH
`define TCP_DEFS_SVH
`define TCP_BUS_W      64
`define TCP_SEL_8      3'h1
`define TCP_SEL_16     3'h2
`define TCP_SEL_32     3'h3
`define TCP_SEL_64     3'h4
`define TCP_SHIFT_8    7'h08
`define TCP_SHIFT_16   7'h10
`define TCP_SHIFT_32   7'h20
`define TCP_SHIFT_64   7'h40
`define TCP_BUS_RST    64'h0
`endif

// ---- rtl/tcp_pkg.sv ----
/*
  types for the trace output port.
  assumes tcp_defs.svh is on the include path.
*/
`include "tcp_defs.svh"
package tcp_pkg;
  typedef logic [2:0] tcp_sel_t;
  typedef enum logic [0:0] {
    TCP_IDLE = 1'b0,
    TCP_SEND = 1'b1
  } tcp_state_e;

  // bits moved per trace cycle; unused codes give zero
  function automatic logic [6:0] tcp_step(input tcp_sel_t sel);
    case (sel)
      `TCP_SEL_8:  tcp_step = `TCP_SHIFT_8;
      `TCP_SEL_16: tcp_step = `TCP_SHIFT_16;
      `TCP_SEL_32: tcp_step = `TCP_SHIFT_32;
      `TCP_SEL_64: tcp_step = `TCP_SHIFT_64;
      default:     tcp_step = 7'h00;
    endcase
  endfunction : tcp_step
endpackage : tcp_pkg

// ---- rtl/tcp_trig_sync.sv ----
/*
  two flop synchroniser plus rising edge detector.
  assumes an asynchronous level input and one core clock.
*/
module tcp_trig_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // async level in, one cycle pulse out
  input  wire logic async_in,
  output logic      rise_pulse
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // first stage only feeds the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  assign rise_pulse = sync_reg & ~last_reg;

  chk_sync_rise_delay: assert property (@(posedge clk) disable iff (!rst_n)
    rise_pulse |-> $past(async_in, 2) && !$past(async_in, 3))
    else $error("edge pulse without a synchronised rise");
endmodule : tcp_trig_sync

// ---- rtl/tcp_trace_port.sv ----
/*
  trace output port: serialises 64 bit trace words onto a shifting bus,
  handles receiver stall and trigger strobes.
  assumes the source holds word_in until word_take, and that the probe
  interface unit uses only the low bits that the width select allows.
*/
`include "tcp_defs.svh"
// Notes on behaviour
// - valid rises only at the start of a fresh word and only in 64 bit mode.
// - each word is shifted down by the selected width so portions land low.
// - in full width mode valid marks the first cycle the word fills the bus.
// - while stall is high the bus and valid are held until after it drops.
// - the probe trigger is double registered and its rise is an event.
// - the probe trigger output is a high pulse of one trace cycle.
// - the on-chip trigger is synchronised and its rise acts as an event.
// - width select may change with the ratio; other codes stop the bus.
module tcp_trace_port
  import tcp_pkg::*;
#(
  parameter int BUS_W = `TCP_BUS_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // trace word source
  input  wire logic [BUS_W-1:0] word_in,
  input  wire logic             word_avail,
  output logic                  word_take,
  // trace bus toward the probe interface unit
  input  wire tcp_sel_t         trace_width_select,
  input  wire logic             trace_receiver_stall,
  output logic [BUS_W-1:0]      trace_word_bus,
  output logic                  trace_word_valid,
  // triggers
  input  wire logic             probe_trigger_in,
  input  wire logic             onchip_trigger_in,
  input  wire logic             trigger_request,
  output logic                  probe_trigger_out,
  output logic                  trigger_event
);
  // ********************************************************
  // trigger inputs
  // ********************************************************
  logic probe_rise;
  logic chip_rise;

  tcp_trig_sync u_probe_sync (
    .clk        (clk),
    .rst_n      (rst_n),
    .async_in   (probe_trigger_in),
    .rise_pulse (probe_rise)
  );
  tcp_trig_sync u_chip_sync (
    .clk        (clk),
    .rst_n      (rst_n),
    .async_in   (onchip_trigger_in),
    .rise_pulse (chip_rise)
  );
  assign trigger_event = probe_rise | chip_rise;

  // ********************************************************
  // shifter
  // ********************************************************
  tcp_state_e       state_reg;
  tcp_state_e       state_next;
  logic [BUS_W-1:0] bus_reg;
  logic [BUS_W-1:0] bus_next;
  logic [6:0]       left_reg;
  logic [6:0]       left_next;
  logic             valid_reg;
  logic             valid_next;
  logic             trig_reg;
  logic             trig_next;
  logic             pend_reg;
  logic             pend_next;
  logic [6:0]       step;
  logic             advance;

  assign step = tcp_step(trace_width_select);
  // unused codes give a zero step, which freezes the bus safely
  // a frozen bus also freezes valid and the trigger strobe, so the
  // probe unit never sees a half-moved portion while the ratio changes
  assign advance = !trace_receiver_stall && (step != 7'h00);
  assign word_take = advance && (state_reg == TCP_IDLE || left_reg <= step)
                     && word_avail;

  always_comb begin
    state_next = state_reg;
    bus_next   = bus_reg;
    left_next  = left_reg;
    valid_next = valid_reg;
    trig_next  = trig_reg;
    pend_next  = pend_reg | trigger_request;
    // a request that lands while stalled waits in pend until the next
    // advancing cycle, so the strobe is never shorter than a trace cycle
    if (advance) begin
      trig_next  = pend_reg;
      pend_next  = trigger_request;
      valid_next = 1'b0;
      if (word_take) begin
        bus_next   = word_in;
        left_next  = `TCP_SHIFT_64;
        state_next = TCP_SEND;
        valid_next = (trace_width_select == `TCP_SEL_64);
      end else if (state_reg == TCP_SEND) begin
        bus_next  = bus_reg >> step;
        left_next = (left_reg > step) ? left_reg - step : 7'h00;
        if (left_reg <= step) begin
          state_next = TCP_IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= TCP_IDLE;
      bus_reg   <= `TCP_BUS_RST;
      left_reg  <= 7'h00;
      valid_reg <= 1'b0;
      trig_reg  <= 1'b0;
      pend_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      bus_reg   <= bus_next;
      left_reg  <= left_next;
      valid_reg <= valid_next;
      trig_reg  <= trig_next;
      pend_reg  <= pend_next;
    end
  end

  assign trace_word_bus    = bus_reg;
  assign trace_word_valid  = valid_reg;
  assign probe_trigger_out = trig_reg;

  // ********************************************************
  // checks
  // ********************************************************
  // valid may sit frozen while the code is unused, so judge it only
  // after an advancing edge, where it was last computed
  chk_valid_full_only: assert property (@(posedge clk) disable iff (!rst_n)
    trace_word_valid && $past(advance)
    |-> $past(trace_width_select) == `TCP_SEL_64)
    else $error("valid outside full width mode");
  chk_valid_new_word: assert property (@(posedge clk) disable iff (!rst_n)
    $past(word_take) && $past(trace_width_select) == `TCP_SEL_64
    |-> trace_word_valid && trace_word_bus == $past(word_in))
    else $error("full width word not flagged");
  chk_shift_down: assert property (@(posedge clk) disable iff (!rst_n)
    $past(advance) && !$past(word_take) && $past(state_reg) == TCP_SEND
    |-> trace_word_bus == ($past(bus_reg) >> $past(step)))
    else $error("bus not shifted by the selected width");
  chk_stall_hold: assert property (@(posedge clk) disable iff (!rst_n)
    trace_receiver_stall |=> $stable(trace_word_bus)
    && $stable(trace_word_valid))
    else $error("bus moved during stall");
  chk_valid_single: assert property (@(posedge clk) disable iff (!rst_n)
    trace_word_valid && advance && !word_take
    |=> !trace_word_valid)
    else $error("valid held without a stall");
  chk_trig_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(probe_trigger_out) && !trace_receiver_stall
    && step != 7'h00 |=> !probe_trigger_out)
    else $error("trigger output longer than one trace cycle");
  chk_trig_cause: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(probe_trigger_out) |-> $past(pend_reg) && $past(advance))
    else $error("trigger output without a request");
  chk_bad_code_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    step == 7'h00 |=> $stable(trace_word_bus))
    else $error("bus moved under an unused width code");
  chk_event_cause: assert property (@(posedge clk) disable iff (!rst_n)
    trigger_event
    |-> ($past(probe_trigger_in, 2) && !$past(probe_trigger_in, 3))
    || ($past(onchip_trigger_in, 2) && !$past(onchip_trigger_in, 3)))
    else $error("trigger event without an input rise");
  chk_word_loaded: assert property (@(posedge clk) disable iff (!rst_n)
    word_take |=> trace_word_bus == $past(word_in))
    else $error("taken word not placed on the bus");
  chk_idle_still: assert property (@(posedge clk) disable iff (!rst_n)
    state_reg == TCP_IDLE && !word_take |=> $stable(trace_word_bus))
    else $error("bus moved with no word in flight");
  chk_valid_from_take: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(trace_word_valid) |-> $past(word_take))
    else $error("valid rose without a fresh word");
  chk_trig_stall_hold: assert property (@(posedge clk) disable iff (!rst_n)
    probe_trigger_out && !advance |=> probe_trigger_out)
    else $error("trigger strobe cut by a stalled cycle");

  // ********************************************************
  // coverage
  // ********************************************************
  // the back to back case is the one that stresses the take timing
  cov_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
    trace_word_valid && word_take);

  cov_full_word: cover property (@(posedge clk) disable iff (!rst_n)
    trace_word_valid);
  cov_stall_word: cover property (@(posedge clk) disable iff (!rst_n)
    trace_word_valid && trace_receiver_stall);
  cov_narrow_shift: cover property (@(posedge clk) disable iff (!rst_n)
    state_reg == TCP_SEND && trace_width_select == `TCP_SEL_8 && advance);
  cov_trig_out: cover property (@(posedge clk) disable iff (!rst_n)
    probe_trigger_out);
endmodule : tcp_trace_port

// ---- bench/tcp_probe_model.sv ----
/*
  behavioural probe interface unit at the far side of the trace bus.
  assumes one core clock; slow makes it stall every other cycle.
*/
module tcp_probe_model #(
  parameter int N = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // trace bus from the port
  input  wire logic [63:0] trace_word_bus,
  input  wire logic        slow,
  output logic             trace_receiver_stall,
  output logic [N-1:0]     low_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // receiver
  // ****
  // only the low n bits are wired, so upper bits never reach the pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trace_receiver_stall <= 1'b0;
      low_bits             <= '0;
    end else begin
      trace_receiver_stall <= slow & ~trace_receiver_stall;
      low_bits             <= trace_word_bus[N-1:0];
    end
  end
endmodule : tcp_probe_model

// ---- bench/tcp_trace_port_bench.sv ----
/*
  bench for the trace output port: reset, then a table of words per
  width, then stall, unused code and trigger cases.
  assumes tcp_pkg, the port and the probe model are compiled first.
*/
module tcp_trace_port_bench import tcp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    tcp_sel_t    sel;
    logic [63:0] word;
    logic [3:0]  steps;
    logic        vld;
  } tcp_row_s;
  localparam tcp_row_s ROWS [4] = '{
    '{3'h1, 64'h0123456789abcdef, 4'h8, 1'b0},
    '{3'h2, 64'hfedcba9876543210, 4'h4, 1'b0},
    '{3'h3, 64'h00ff00ff5a5aa5a5, 4'h2, 1'b0},
    '{3'h4, 64'h8000000000000001, 4'h1, 1'b1}};
  logic        clk;
  logic        rst_n;
  logic [63:0] word_in;
  logic        word_avail;
  logic        word_take;
  tcp_sel_t    trace_width_select;
  logic        trace_receiver_stall;
  logic [63:0] trace_word_bus;
  logic        trace_word_valid;
  logic        probe_trigger_in;
  logic        onchip_trigger_in;
  logic        trigger_request;
  logic        probe_trigger_out;
  logic        trigger_event;
  logic        slow;
  logic        stl_q = 1'b0;
  logic [63:0] bus_q;
  int          n_fail, compares, cyc, ev_cnt, out_cnt;

  tcp_trace_port tcp_trace_port_inst (.clk(clk), .rst_n(rst_n),
    .word_in(word_in), .word_avail(word_avail), .word_take(word_take),
    .trace_width_select(trace_width_select),
    .trace_receiver_stall(trace_receiver_stall),
    .trace_word_bus(trace_word_bus), .trace_word_valid(trace_word_valid),
    .probe_trigger_in(probe_trigger_in),
    .onchip_trigger_in(onchip_trigger_in),
    .trigger_request(trigger_request),
    .probe_trigger_out(probe_trigger_out), .trigger_event(trigger_event));
  tcp_probe_model tcp_probe_model_inst (.clk(clk), .rst_n(rst_n),
    .trace_word_bus(trace_word_bus), .slow(slow),
    .trace_receiver_stall(trace_receiver_stall), .low_bits());

  // ****
  // helpers
  // ****
  task chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  // stalled portions are skipped here; the monitor checks them
  task send(input tcp_row_s r);
    int n;
    @(posedge clk);
    trace_width_select <= r.sel;
    word_in            <= r.word;
    word_avail         <= 1'b1;
    n = 0;
    do @(negedge clk); while (word_take !== 1'b1 && ++n < 40);
    chk("take", 64'h1, 64'(n < 40));
    @(posedge clk);
    word_avail <= 1'b0;
    for (int k = 0; k < r.steps; k++) begin
      do @(negedge clk); while (stl_q);
      chk("bus", r.word >> (k * (64 / r.steps)), trace_word_bus);
      chk("valid", 64'(r.vld && k == 0), 64'(trace_word_valid));
    end
  endtask : send
  task trig_in(input bit onchip);
    @(posedge clk);
    ev_cnt = 0;
    if (onchip) onchip_trigger_in <= 1'b1;
    else probe_trigger_in <= 1'b1;
    repeat (8) @(posedge clk);
    onchip_trigger_in <= 1'b0;
    probe_trigger_in  <= 1'b0;
    repeat (8) @(posedge clk);
    chk("event count", 64'h1, 64'(ev_cnt));
  endtask : trig_in

  // ****
  // clock, monitor and timeout
  // ****
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) stl_q <= trace_receiver_stall;
  always @(negedge clk) begin
    if (rst_n && stl_q) chk("held bus", bus_q, trace_word_bus);
    bus_q = trace_word_bus;
    if (trigger_event === 1'b1) ev_cnt++;
    if (probe_trigger_out === 1'b1) out_cnt++;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end

  // ****
  // tests
  // ****
  initial begin
    rst_n = 1'b0;
    word_in = '0;
    word_avail = 1'b0;
    trace_width_select = 3'h4;
    probe_trigger_in = 1'b0;
    onchip_trigger_in = 1'b0;
    trigger_request = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge clk);
    chk("reset bus", 64'h0, trace_word_bus);
    chk("reset out", 64'h0, {trace_word_valid, probe_trigger_out});
    rst_n <= 1'b1;
    foreach (ROWS[i]) send(ROWS[i]);
    slow <= 1'b1;
    send(ROWS[1]);
    send(ROWS[3]);
    slow <= 1'b0;
    @(posedge clk);
    trace_width_select <= 3'h0;
    word_avail         <= 1'b1;
    repeat (4) @(negedge clk);
    chk("unused take", 64'h0, 64'(word_take));
    @(posedge clk);
    word_avail         <= 1'b0;
    trace_width_select <= 3'h4;
    trig_in(1'b0);
    trig_in(1'b1);
    @(posedge clk);
    out_cnt = 0;
    trigger_request <= 1'b1;
    @(posedge clk);
    trigger_request <= 1'b0;
    repeat (6) @(posedge clk);
    chk("trigger out", 64'h1, 64'(out_cnt));
    results();
  end
endmodule : tcp_trace_port_bench
